// File: verilog/bsc_exec_regs.svh
// Purpose: Constants for the bit-set, skip-if-set and call execution slice.
// Assumes: 14-bit instruction words, 13-bit program counter, 8-bit file registers.
// Notes:   Counts are in quarter phases of one instruction cycle.
// Contract
// - Opcode 01 01bb sets bit b, no flags.
// - Bit set: decode, read, modify, write quarters.
// - Opcode 01 11bb tests bit, no flags.
// - Tested bit one: discard next, run no-op.
// - Call pushes PC plus one, two cycles.
// - Opcode 10 0k loads literal into PC<10:0>.
`ifndef BSC_EXEC_REGS_SVH
`define BSC_EXEC_REGS_SVH
`define OPC_BIT_SET     4'h5
`define OPC_SKIP_SET    4'h7
`define OPC_CALL        3'h4
`define FIELD_BIT_LO    7
`define FIELD_FILE_HI   6
`define LATCH_PC_HI     4
`define LATCH_PC_LO     3
`define QUARTERS        4
`endif

// File: verilog/bsc_exec_pkg.sv
// Purpose: Types for the bit-set, skip-if-set and call execution slice.
// Assumes: One-hot codes for the quarter sequencer and the decoded operation.
// Notes:   Constants live in the register header, types live here.
package bsc_exec_pkg;
  typedef enum logic [3:0] {
    Q1 = 4'h1,
    Q2 = 4'h2,
    Q3 = 4'h4,
    Q4 = 4'h8
  } quarter_e;
  typedef enum logic [3:0] {
    OP_NONE  = 4'h1,
    OP_SET   = 4'h2,
    OP_SKIP  = 4'h4,
    OP_CALL  = 4'h8
  } op_e;
endpackage

// File: verilog/bit_skip_and_call_exec.sv
// Purpose: Executes bit set, bit test skip-if-set and call over four quarters.
// Assumes: instr is stable from Q1 to Q4 of a cycle; file data returns in the same quarter.
// Notes:   Other opcodes pass as no-ops here; a forced no-op cycle ignores instr.
`timescale 1ns/1ps
`include "bsc_exec_regs.svh"
module bit_skip_and_call_exec
  import bsc_exec_pkg::*;
#(
  parameter int PC_W = 13
) (
  // Clock, reset and enable
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  input  wire logic            clk_en,
  // Instruction and program counter
  input  wire logic [13:0]     instr,
  input  wire logic [PC_W-1:0] pc_in,
  input  wire logic [7:0]      pc_upper_latch,
  // File register port
  input  wire logic [7:0]      file_rdata,
  output logic      [6:0]      file_addr,
  output logic                 file_rd,
  output logic                 file_wr,
  output logic      [7:0]      file_wdata,
  // Program counter and stack
  output logic                 pc_load,
  output logic      [PC_W-1:0] pc_new,
  output logic                 stack_push,
  output logic      [PC_W-1:0] stack_top,
  // Cycle status
  output logic                 nop_cycle,
  output logic      [3:0]      quarter
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration check.

  // The call target is two latch bits on top of an 11-bit literal, so the
  // program counter can be neither wider nor narrower than 13 bits.
  if (PC_W != 13) begin : g_pc_width_check
    $error("PC_W must be 13");
  end

  //////////////////////////////////////////////////////////////////////////////
  // State and decode.

  quarter_e   q_q;
  op_e        op_q;
  logic       force_nop_q;
  logic [7:0] data_q;
  logic [2:0] bsel;
  logic       is_set;
  logic       is_skip;
  logic       is_call;
  logic       skip_taken_d;
  logic       nop_next_d;
  logic       call_q3;

  // The bit and file fields sit in the same place for both bit instructions.
  assign bsel    = instr[`FIELD_BIT_LO+2:`FIELD_BIT_LO];
  assign is_set  = instr[13:10] == `OPC_BIT_SET;
  assign is_skip = instr[13:10] == `OPC_SKIP_SET;
  assign is_call = instr[13:11] == `OPC_CALL;

  // A skip is taken on the bit read in Q2; a call always buys a no-op cycle.
  assign skip_taken_d = op_q == OP_SKIP && data_q[bsel];
  assign nop_next_d   = skip_taken_d || op_q == OP_CALL;
  assign call_q3      = q_q == Q3 && op_q == OP_CALL;

  //////////////////////////////////////////////////////////////////////////////
  // Quarter sequencer.

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q_q <= Q1;
    end else if (clk_en) begin
      case (q_q)
        Q1:      q_q <= Q2;
        Q2:      q_q <= Q3;
        Q3:      q_q <= Q4;
        Q4:      q_q <= Q1;
        default: q_q <= Q1;
      endcase
    end
  end

  // The output copy runs alongside the sequencer so that it comes from a flop.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      quarter <= 4'h1;
    end else if (clk_en) begin
      case (q_q)
        Q1:      quarter <= 4'h2;
        Q2:      quarter <= 4'h4;
        Q3:      quarter <= 4'h8;
        Q4:      quarter <= 4'h1;
        default: quarter <= 4'h1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode in Q1.

  // The word fetched behind a taken skip or a call is already on instr when
  // the no-op cycle starts, so it is thrown away here and never executed.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      op_q <= OP_NONE;
    end else if (clk_en && q_q == Q1) begin
      if (force_nop_q) begin
        op_q <= OP_NONE;
      end else if (is_set) begin
        op_q <= OP_SET;
      end else if (is_skip) begin
        op_q <= OP_SKIP;
      end else if (is_call) begin
        op_q <= OP_CALL;
      end else begin
        op_q <= OP_NONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // No-op cycle control.

  // Both registers load only in Q4, so they cover exactly the four quarters
  // of the next cycle; that cycle decodes as a no-op and so clears them again.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      force_nop_q <= 1'h0;
    end else if (clk_en && q_q == Q4) begin
      force_nop_q <= nop_next_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nop_cycle <= 1'h0;
    end else if (clk_en && q_q == Q4) begin
      nop_cycle <= nop_next_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // File register access: read in Q2, modify in Q3, write in Q4.

  // The address simply follows instr; it only means something while file_rd
  // or file_wr is high, and instr is held for the whole cycle.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      file_addr <= 7'h00;
    end else if (clk_en) begin
      file_addr <= instr[`FIELD_FILE_HI:0];
    end
  end

  // A bit set or a skip asks for its operand in Q2, unless the cycle is a no-op.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      file_rd <= 1'h0;
    end else if (clk_en) begin
      file_rd <= q_q == Q1 && !force_nop_q && (is_set || is_skip);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      file_wr <= 1'h0;
    end else if (clk_en) begin
      file_wr <= q_q == Q3 && op_q == OP_SET;
    end
  end

  // The operand is taken at the end of Q2, on the same edge that drops file_rd.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      data_q <= 8'h00;
    end else if (clk_en && file_rd) begin
      data_q <= file_rdata;
    end
  end

  // Only the chosen bit changes; no status flag is touched by either bit op.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      file_wdata <= 8'h00;
    end else if (clk_en && q_q == Q3 && op_q == OP_SET) begin
      file_wdata <= data_q | (8'h01 << bsel);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Call: push return address and load target in Q4 of the first cycle.

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc_load <= 1'h0;
    end else if (clk_en) begin
      pc_load <= call_q3;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stack_push <= 1'h0;
    end else if (clk_en) begin
      stack_push <= call_q3;
    end
  end

  // The return address wraps at the top of program memory like the counter.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stack_top <= '0;
    end else if (clk_en && call_q3) begin
      stack_top <= pc_in + 13'h0001;
    end
  end

  // The upper page bits come from the latch, not from the current counter.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc_new <= '0;
    end else if (clk_en && call_q3) begin
      pc_new <= {pc_upper_latch[`LATCH_PC_HI:`LATCH_PC_LO],
                 instr[10:0]};
    end
  end

endmodule

// File: testbench/bsc_exec_properties.sv
// Purpose: Assertions for the bit-set, skip and call execution slice.
// Assumes: clk_en held high, so one quarter passes per clock.
// Notes:   Bound to every instance of the slice.
`timescale 1ns/1ps
module bsc_exec_properties #(
  parameter int PC_W = 13
) (
  // Clock, reset and enable
  input wire logic            sys_clk,
  input wire logic            resetn,
  input wire logic            clk_en,
  // Instruction and program counter
  input wire logic [13:0]     instr,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0]      pc_upper_latch,
  // File register port
  input wire logic [7:0]      file_rdata,
  input wire logic [6:0]      file_addr,
  input wire logic            file_rd,
  input wire logic            file_wr,
  input wire logic [7:0]      file_wdata,
  // Program counter and stack
  input wire logic            pc_load,
  input wire logic [PC_W-1:0] pc_new,
  input wire logic            stack_push,
  input wire logic [PC_W-1:0] stack_top,
  // Cycle status
  input wire logic            nop_cycle,
  input wire logic [3:0]      quarter
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_SET_BIT: assert property (file_wr |-> instr[13:10] == 4'h5 &&
    file_wdata == ($past(file_rdata, 2) | 8'h01 << instr[9:7])) else $error("bad set data");
  AST_SET_QTR: assert property (file_wr |-> quarter == 4'b1000 && $past(file_rd, 2))
    else $error("set write out of order");
  AST_READ_F: assert property (file_rd |-> quarter == 4'b0010 && file_addr == instr[6:0])
    else $error("bad file read");
  AST_NOP_LEN: assert property ($rose(nop_cycle) |-> quarter == 4'b0001 ##0 nop_cycle [*4])
    else $error("bad no-op cycle");
  AST_NOP_IDLE: assert property (nop_cycle |-> !file_wr && !pc_load)
    else $error("action in no-op cycle");
  AST_PUSH: assert property (stack_push |-> pc_load && stack_top == pc_in + 1'b1
    ##1 nop_cycle [*4]) else $error("bad call push");
  AST_LIT: assert property (pc_load |-> instr[13:11] == 3'h4 && pc_new[10:0] == instr[10:0])
    else $error("bad call literal");
  AST_PAGE: assert property (pc_load |-> pc_new[12:11] == pc_upper_latch[4:3])
    else $error("bad call page bits");
  cover property (file_wr);
  cover property ($rose(nop_cycle) && !$past(pc_load));
  cover property (pc_load);
endmodule
bind bit_skip_and_call_exec bsc_exec_properties #(
  .PC_W(PC_W)
) bsc_exec_properties_i (
  .sys_clk        (sys_clk),
  .resetn         (resetn),
  .clk_en         (clk_en),
  .instr          (instr),
  .pc_in          (pc_in),
  .pc_upper_latch (pc_upper_latch),
  .file_rdata     (file_rdata),
  .file_addr      (file_addr),
  .file_rd        (file_rd),
  .file_wr        (file_wr),
  .file_wdata     (file_wdata),
  .pc_load        (pc_load),
  .pc_new         (pc_new),
  .stack_push     (stack_push),
  .stack_top      (stack_top),
  .nop_cycle      (nop_cycle),
  .quarter        (quarter)
);

// File: testbench/test_bit_skip_and_call_exec.sv
// Purpose: Self-checking bench for the bit-set, skip and call execution slice.
// Assumes: One instruction every four clocks with clk_en held high.
// Notes:   The driver queues expected values and the monitor takes them in order.
`timescale 1ns/1ps
module test_bit_skip_and_call_exec;
  logic        sys_clk = 0, resetn = 0, clk_en = 1, nop = 0;
  logic [13:0] instr = 0;
  logic [12:0] pc_in = 0, pc_new, stack_top;
  logic [7:0]  pc_upper_latch = 0, file_rdata = 0, file_wdata;
  logic [6:0]  file_addr;
  logic        file_rd, file_wr, pc_load, stack_push, nop_cycle;
  logic [3:0]  quarter;
  logic [3:0]  qx = 4'h1;
  logic [12:0] q[$];
  int          error_cnt = 0, num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  bit_skip_and_call_exec bit_skip_and_call_exec_i (
    .sys_clk        (sys_clk),
    .resetn         (resetn),
    .clk_en         (clk_en),
    .instr          (instr),
    .pc_in          (pc_in),
    .pc_upper_latch (pc_upper_latch),
    .file_rdata     (file_rdata),
    .file_addr      (file_addr),
    .file_rd        (file_rd),
    .file_wr        (file_wr),
    .file_wdata     (file_wdata),
    .pc_load        (pc_load),
    .pc_new         (pc_new),
    .stack_push     (stack_push),
    .stack_top      (stack_top),
    .nop_cycle      (nop_cycle),
    .quarter        (quarter)
  );
  task chk(string n, logic [12:0] s, logic [12:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  function logic [12:0] nx();
    return q.size() ? q.pop_front() : 'x;
  endfunction
  // An empty queue yields unknown, so any unexpected write shows as a mismatch.
  // The quarter is followed by its own one-hot ring, started at release.
  always @(negedge sys_clk) if (resetn) begin
    chk("quarter", 13'(quarter), 13'(qx));
    qx = {qx[2:0], qx[3]};
    if (quarter === 4'b0010) chk("nop_cycle", nop_cycle, nx());
    if (file_rd !== 1'b0) chk("file_addr", file_addr, nx());
    if (file_wr !== 1'b0) chk("file_wdata", file_wdata, nx());
    if (pc_load !== 1'b0) begin
      chk("pc_new", pc_new, nx());
      chk("stack_top", stack_top, nx());
      chk("stack_push", stack_push, 13'h1);
    end
  end
  task op(input logic [13:0] i);
    instr = i;
    file_rdata = $urandom;
    pc_in = $urandom;
    pc_upper_latch = $urandom;
    q.push_back({12'h0, nop});
    if (nop) nop = 0;
    else if (i[13:10] == 4'h5) begin
      q.push_back({6'h0, i[6:0]});
      q.push_back({5'h0, file_rdata | 8'h01 << i[9:7]});
    end else if (i[13:10] == 4'h7) begin
      q.push_back({6'h0, i[6:0]});
      nop = file_rdata[i[9:7]];
    end else if (i[13:11] == 3'h4) begin
      q.push_back({pc_upper_latch[4:3], i[10:0]});
      q.push_back(pc_in + 13'h1);
      nop = 1;
    end
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #10000;
    error_cnt++;
    close_out();
  end
  initial begin
    void'($urandom(29027));
    repeat (3) @(posedge sys_clk);
    #1 resetn = 1;
    for (int b = 0; b < 8; b++) begin
      op({4'h5, b[2:0], 7'($urandom)});
      op({4'h7, b[2:0], 7'($urandom)});
      op({4'h7, b[2:0], 7'($urandom)});
      // A bit-clear word belongs to another slice and must pass as a no-op.
      op({4'h4, 10'($urandom)});
    end
    // A call inside the no-op cycle of another call must be dropped.
    op({3'h4, 11'h7FF});
    op({3'h4, 11'h000});
    op({3'h4, 11'($urandom)});
    op(14'h0);
    chk("queue_left", 13'(q.size()), 13'h0);
    close_out();
  end
endmodule
